/* core/mip_pkg.sv */
// Contract
// R1: Pin request clear bit means low level sensitive; set means falling edges only.
// R2: Hold hardware requests pending until the current instruction completes.
// R3: Serial, transfer, accumulator and timer-wrap vectors FFD6 to FFDF, locally gated.
// R4: Compares FFE0-FFE9, captures FFEA-FFEF, periodic tick FFF0, locally gated.
// R5: Pin NMI FFF4, trap FFF6, illegal FFF8, watchdog FFFA, clock FFFC, reset FFFE.
// R6: Merge serial causes on one vector, each under its own enable; receive full and overrun share one enable.
// R7: Pin request and strobe handshake share vector FFF2; only strobe is gated.
// R8: Fifteen sources masked by I; each on-chip source also needs its enable.
// R9: Trap not fetched while a request pends; once begun, nothing preempts it.
// R10: Illegal opcodes raise a non-maskable request to the illegal vector.
// R11: Reset sets both X and I mask bits.
// R12: Software may clear X by transfer to flags, never set it.
// R13: Servicing an I source sets I and leaves X unchanged.
// R14: Servicing the pin NMI sets both X and I.
// R15: Return from service restores X and I to their stacked values.
// R16: Pin NMI ranks above every I-maskable source.
// R17: Fixed order: reset, clock fail, watchdog, illegal, pin NMI.
// R18: Promoted source ranks first among I sources, keeps masks and vector.
// R19: Promote register is writable only while I is one.
// R20: Clock failure resets only while monitor enable set; enable always writable.
// R21: Protected option bits take one write within 64 cycles of reset; here they take any write while special_test_mode is high.
// R22: Promote field resets to 0101, promoting the pin request.
// R23: Promote code selects exactly one I source.
// R24: Present only the single highest-ranked request and its vector.
package mip_pkg;
  localparam logic [2:0] ADDR_CFG = 3'h0, ADDR_PROMO = 3'h1;
  localparam logic [2:0] ADDR_EN_PER = 3'h2, ADDR_EN_TMR = 3'h3;
  localparam logic [2:0] ADDR_EN_SER = 3'h4, ADDR_STATUS = 3'h5;
  localparam logic [2:0] ADDR_VEC_LO = 3'h6;
  localparam int CFG_EDGE = 5, CFG_CME = 3;
  localparam logic [7:0] CFG_RESET = 8'h10;
  localparam logic [7:0] CFG_PROT_MASK = 8'h33;
  localparam logic [7:0] CFG_FREE_MASK = 8'hC8;
  localparam int WINDOW_CYC = 64;
  localparam logic [3:0] PROMO_RESET = 4'h5;
  localparam int EN_SPI = 0, EN_PAI = 1, EN_PAOV = 2, EN_TOF = 3;
  localparam int EN_RTI = 4, EN_STRB = 5;
  localparam int EN_CMP_LSB = 0, EN_CAP_LSB = 5;
  localparam int EN_RX = 0, EN_IDLE = 1, EN_TXE = 2, EN_TXC = 3;
  localparam int NUM_ISRC = 15;
  localparam int SRC_IRQ = 0, SRC_RTI = 1, SRC_IC1 = 2, SRC_OC1 = 5;
  localparam int SRC_TOF = 10, SRC_PAOV = 11, SRC_PAI = 12;
  localparam int SRC_SPI = 13, SRC_SCI = 14;
  localparam logic [15:0] VEC_SCI = 16'hFFD6, VEC_SPI = 16'hFFD8;
  localparam logic [15:0] VEC_PAI = 16'hFFDA, VEC_PAOV = 16'hFFDC;
  localparam logic [15:0] VEC_TOF = 16'hFFDE, VEC_OC5 = 16'hFFE0;
  localparam logic [15:0] VEC_OC4 = 16'hFFE2, VEC_OC3 = 16'hFFE4;
  localparam logic [15:0] VEC_OC2 = 16'hFFE6, VEC_OC1 = 16'hFFE8;
  localparam logic [15:0] VEC_IC3 = 16'hFFEA, VEC_IC2 = 16'hFFEC;
  localparam logic [15:0] VEC_IC1 = 16'hFFEE, VEC_RTI = 16'hFFF0;
  localparam logic [15:0] VEC_IRQ = 16'hFFF2, VEC_PSEUDO_NONMASKABLE_PIN = 16'hFFF4;
  localparam logic [15:0] VEC_SWI = 16'hFFF6, VEC_ILL = 16'hFFF8;
  localparam logic [15:0] VEC_WDF = 16'hFFFA, VEC_CMF = 16'hFFFC;
  localparam logic [15:0] VEC_RESET = 16'hFFFE;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_PRESENT = 2'b01, ST_SWI = 2'b10
  } mip_state_e;
  typedef enum logic [2:0] {
    CLS_RESET = 3'b000, CLS_CMF = 3'b001, CLS_WDF = 3'b010,
    CLS_ILL = 3'b011, CLS_PSEUDO_NONMASKABLE_PIN = 3'b100, CLS_SWI = 3'b101,
    CLS_IBIT = 3'b110
  } mip_cls_e;
  function automatic logic [15:0] ivec(input logic [3:0] idx);
    case (idx) // [R3] [R4]
      4'h0: ivec = VEC_IRQ;
      4'h1: ivec = VEC_RTI;
      4'h2: ivec = VEC_IC1;
      4'h3: ivec = VEC_IC2;
      4'h4: ivec = VEC_IC3;
      4'h5: ivec = VEC_OC1;
      4'h6: ivec = VEC_OC2;
      4'h7: ivec = VEC_OC3;
      4'h8: ivec = VEC_OC4;
      4'h9: ivec = VEC_OC5;
      4'hA: ivec = VEC_TOF;
      4'hB: ivec = VEC_PAOV;
      4'hC: ivec = VEC_PAI;
      4'hD: ivec = VEC_SPI;
      default: ivec = VEC_SCI;
    endcase
  endfunction
  function automatic logic [3:0] promo_to_idx(input logic [3:0] code);
    case (code) // [R23]
      4'h0: promo_to_idx = 4'hA;
      4'h1: promo_to_idx = 4'hB;
      4'h2: promo_to_idx = 4'hC;
      4'h3: promo_to_idx = 4'hD;
      4'h4: promo_to_idx = 4'hE;
      4'h7: promo_to_idx = 4'h1;
      4'h8: promo_to_idx = 4'h2;
      4'h9: promo_to_idx = 4'h3;
      4'hA: promo_to_idx = 4'h4;
      4'hB: promo_to_idx = 4'h5;
      4'hC: promo_to_idx = 4'h6;
      4'hD: promo_to_idx = 4'h7;
      4'hE: promo_to_idx = 4'h8;
      4'hF: promo_to_idx = 4'h9;
      // Reserved code falls back to the pin request
      default: promo_to_idx = 4'h0;
    endcase
  endfunction
endpackage

/* core/mip_sync2.sv */
module mip_sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '1
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;
  initial begin
    if (W < 1) $error("mip_sync2: W must be positive");
  end
  always_ff @(posedge clock) begin
    if (!nrst) begin
      meta_reg <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule

/* core/mip_prio.sv */
module mip_prio #(
  parameter int N = mip_pkg::NUM_ISRC
) (
  input wire logic [N-1:0] req,
  input wire logic [3:0] promo_code,
  output logic hit,
  output logic [3:0] idx
);
  logic [3:0] pidx;
  initial begin
    if (N != mip_pkg::NUM_ISRC) $error("mip_prio: N must be 15");
  end
  always_comb begin
    pidx = mip_pkg::promo_to_idx(promo_code);
    hit = |req;
    idx = 4'h0;
    // Lowest index wins among the fixed order
    for (int k = N - 1; k >= 0; k--) begin
      if (req[k]) idx = 4'(k);
    end
    if (req[pidx]) idx = pidx; // [R18]
  end
endmodule

/* core/mip_top.sv */
module mip_top (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic special_test_mode,
  input wire logic ext_request_n_pin,
  input wire logic pseudo_nonmaskable_pin_n,
  input wire logic clock_slow_detect,
  input wire logic watchdog_fail,
  input wire logic illegal_opcode,
  input wire logic insn_boundary,
  input wire logic swi_begin,
  input wire logic tap_write,
  input wire logic tap_x,
  input wire logic tap_i,
  input wire logic rti_exec,
  input wire logic rti_x,
  input wire logic rti_i,
  input wire logic vector_taken,
  input wire logic serial_periph_req,
  input wire logic accum_edge_req,
  input wire logic accum_overflow_req,
  input wire logic timer_wrap_req,
  input wire logic [4:0] compare_req,
  input wire logic [2:0] capture_req,
  input wire logic periodic_tick_req,
  input wire logic strobe_handshake_req,
  input wire logic rx_full_req,
  input wire logic rx_overrun_req,
  input wire logic line_idle_req,
  input wire logic tx_empty_req,
  input wire logic tx_done_req,
  output logic irq_valid,
  output logic [15:0] irq_vector,
  output logic x_mask,
  output logic i_mask,
  output logic swi_fetch_ok,
  output logic clock_monitor_reset
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] cfg_reg;
  logic [3:0] promo_reg;
  logic [7:0] en_per_reg;
  logic [7:0] en_tmr_reg;
  logic [3:0] en_ser_reg;
  logic cfg_once_reg;
  logic [6:0] win_cnt_reg;
  logic window_open;
  logic prot_ok;
  logic [2:0] pins_sync;
  logic ext_n_sync;
  logic pseudo_nonmaskable_pin_n_sync;
  logic slow_sync;
  logic ext_prev_reg;
  logic ext_fall;
  logic edge_flag_reg;
  logic ext_req;
  logic sci_req;
  logic irq_src;
  logic [mip_pkg::NUM_ISRC-1:0] ireq;
  logic [mip_pkg::NUM_ISRC-1:0] ireq_masked;
  logic ihit;
  logic [3:0] widx;
  logic rst_pend_reg;
  logic cmf_pend_reg;
  logic wdf_pend_reg;
  logic ill_pend_reg;
  logic any_next;
  logic [15:0] vec_next;
  mip_pkg::mip_cls_e cls_next;
  mip_pkg::mip_cls_e cls_reg;
  mip_pkg::mip_state_e state_reg;
  logic [3:0] sel_idx_reg;
  logic take;
  logic [7:0] rd_mux;
  logic clock_monitor_enable;
  logic edge_mode;

  assign clock_monitor_enable = cfg_reg[mip_pkg::CFG_CME];
  assign edge_mode = cfg_reg[mip_pkg::CFG_EDGE];
  assign take = vector_taken && irq_valid;

  ////////////////////////////////////////////////////////////////////////////
  // Pins arrive from outside the clock domain
  mip_sync2 #(.W(3), .RST_VAL(3'h7)) u_sync (
    .clock(clock),
    .nrst(nrst),
    .d({clock_slow_detect, pseudo_nonmaskable_pin_n, ext_request_n_pin}),
    .q(pins_sync)
  );
  assign ext_n_sync = pins_sync[0];
  assign pseudo_nonmaskable_pin_n_sync = pins_sync[1];
  assign slow_sync = pins_sync[2];

  ////////////////////////////////////////////////////////////////////////////
  // Protected option bits: one write inside the window after reset, any write while special_test_mode is high
  always_ff @(posedge clock) begin
    if (!nrst) begin
      win_cnt_reg <= 7'h00;
    end else if (win_cnt_reg != 7'(mip_pkg::WINDOW_CYC)) begin
      win_cnt_reg <= win_cnt_reg + 7'h01; // [R21]
    end
  end
  assign window_open = !cfg_once_reg &&
                       (win_cnt_reg != 7'(mip_pkg::WINDOW_CYC));
  assign prot_ok = special_test_mode || window_open; // [R21]

  always_ff @(posedge clock) begin
    if (!nrst) begin
      cfg_once_reg <= 1'b0;
    end else if (reg_wr && reg_addr == mip_pkg::ADDR_CFG) begin
      cfg_once_reg <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      cfg_reg <= mip_pkg::CFG_RESET; // [R20]
    end else if (reg_wr && reg_addr == mip_pkg::ADDR_CFG) begin
      // Bit 2 is not implemented and stays zero
      if (prot_ok) begin
        cfg_reg <= reg_wdata &
                   (mip_pkg::CFG_PROT_MASK | mip_pkg::CFG_FREE_MASK);
      end else begin
        cfg_reg <= (cfg_reg & mip_pkg::CFG_PROT_MASK) |
                   (reg_wdata & mip_pkg::CFG_FREE_MASK); // [R20] [R21]
      end
    end
  end

  // Changing priority with I clear could race a resolution in flight
  always_ff @(posedge clock) begin
    if (!nrst) begin
      promo_reg <= mip_pkg::PROMO_RESET; // [R22]
    end else if (reg_wr && reg_addr == mip_pkg::ADDR_PROMO && i_mask) begin
      promo_reg <= reg_wdata[3:0]; // [R19]
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      en_per_reg <= 8'h00;
      en_tmr_reg <= 8'h00;
      en_ser_reg <= 4'h0;
    end else if (reg_wr) begin
      if (reg_addr == mip_pkg::ADDR_EN_PER) en_per_reg <= reg_wdata;
      if (reg_addr == mip_pkg::ADDR_EN_TMR) en_tmr_reg <= reg_wdata;
      if (reg_addr == mip_pkg::ADDR_EN_SER) en_ser_reg <= reg_wdata[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin request: level or falling edge
  always_ff @(posedge clock) begin
    if (!nrst) ext_prev_reg <= 1'b1;
    else ext_prev_reg <= ext_n_sync;
  end
  assign ext_fall = ext_prev_reg && !ext_n_sync;

  // A new edge in the clearing cycle survives
  always_ff @(posedge clock) begin
    if (!nrst) begin
      edge_flag_reg <= 1'b0;
    end else if (edge_mode && ext_fall) begin
      edge_flag_reg <= 1'b1; // [R1]
    end else if (take && cls_reg == mip_pkg::CLS_IBIT &&
                 sel_idx_reg == 4'(mip_pkg::SRC_IRQ)) begin
      edge_flag_reg <= 1'b0;
    end
  end
  assign ext_req = edge_mode ? edge_flag_reg : !ext_n_sync; // [R1]

  ////////////////////////////////////////////////////////////////////////////
  // Local gating of the I-maskable sources; the pin request passes ungated
  assign sci_req =
    ((rx_full_req || rx_overrun_req) && en_ser_reg[mip_pkg::EN_RX]) ||
    (line_idle_req && en_ser_reg[mip_pkg::EN_IDLE]) ||
    (tx_empty_req && en_ser_reg[mip_pkg::EN_TXE]) ||
    (tx_done_req && en_ser_reg[mip_pkg::EN_TXC]); // [R6]
  assign irq_src = ext_req ||
    (strobe_handshake_req && en_per_reg[mip_pkg::EN_STRB]); // [R7]

  always_comb begin
    ireq = '0;
    ireq[mip_pkg::SRC_IRQ] = irq_src;
    ireq[mip_pkg::SRC_RTI] = periodic_tick_req &&
                             en_per_reg[mip_pkg::EN_RTI]; // [R8]
    ireq[mip_pkg::SRC_IC1 +: 3] = capture_req &
                                  en_tmr_reg[mip_pkg::EN_CAP_LSB +: 3];
    ireq[mip_pkg::SRC_OC1 +: 5] = compare_req &
                                  en_tmr_reg[mip_pkg::EN_CMP_LSB +: 5];
    ireq[mip_pkg::SRC_TOF] = timer_wrap_req && en_per_reg[mip_pkg::EN_TOF];
    ireq[mip_pkg::SRC_PAOV] = accum_overflow_req &&
                              en_per_reg[mip_pkg::EN_PAOV];
    ireq[mip_pkg::SRC_PAI] = accum_edge_req && en_per_reg[mip_pkg::EN_PAI];
    ireq[mip_pkg::SRC_SPI] = serial_periph_req &&
                             en_per_reg[mip_pkg::EN_SPI];
    ireq[mip_pkg::SRC_SCI] = sci_req;
  end
  assign ireq_masked = ireq & {mip_pkg::NUM_ISRC{!i_mask}}; // [R8]

  mip_prio #(.N(mip_pkg::NUM_ISRC)) u_prio (
    .req(ireq_masked),
    .promo_code(promo_reg),
    .hit(ihit),
    .idx(widx)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Non-maskable causes latch until their vector is taken
  always_ff @(posedge clock) begin
    if (!nrst) rst_pend_reg <= 1'b1;
    else if (take && cls_reg == mip_pkg::CLS_RESET) rst_pend_reg <= 1'b0;
  end
  always_ff @(posedge clock) begin
    if (!nrst) cmf_pend_reg <= 1'b0;
    else if (clock_monitor_enable && !slow_sync) cmf_pend_reg <= 1'b1; // [R20]
    else if (take && cls_reg == mip_pkg::CLS_CMF) cmf_pend_reg <= 1'b0;
  end
  always_ff @(posedge clock) begin
    if (!nrst) wdf_pend_reg <= 1'b0;
    else if (watchdog_fail) wdf_pend_reg <= 1'b1;
    else if (take && cls_reg == mip_pkg::CLS_WDF) wdf_pend_reg <= 1'b0;
  end
  always_ff @(posedge clock) begin
    if (!nrst) ill_pend_reg <= 1'b0;
    else if (illegal_opcode) ill_pend_reg <= 1'b1; // [R10]
    else if (take && cls_reg == mip_pkg::CLS_ILL) ill_pend_reg <= 1'b0;
  end
  always_ff @(posedge clock) begin
    if (!nrst) clock_monitor_reset <= 1'b0;
    else clock_monitor_reset <= clock_monitor_enable && !slow_sync; // [R20]
  end

  ////////////////////////////////////////////////////////////////////////////
  // Priority resolution, one winner
  always_comb begin
    any_next = 1'b1;
    vec_next = mip_pkg::VEC_RESET;
    cls_next = mip_pkg::CLS_RESET;
    if (rst_pend_reg) begin // [R17]
      vec_next = mip_pkg::VEC_RESET; // [R5]
    end else if (cmf_pend_reg) begin
      vec_next = mip_pkg::VEC_CMF;
      cls_next = mip_pkg::CLS_CMF;
    end else if (wdf_pend_reg) begin
      vec_next = mip_pkg::VEC_WDF;
      cls_next = mip_pkg::CLS_WDF;
    end else if (ill_pend_reg) begin
      vec_next = mip_pkg::VEC_ILL; // [R10]
      cls_next = mip_pkg::CLS_ILL;
    end else if (!pseudo_nonmaskable_pin_n_sync && !x_mask) begin // [R16]
      vec_next = mip_pkg::VEC_PSEUDO_NONMASKABLE_PIN;
      cls_next = mip_pkg::CLS_PSEUDO_NONMASKABLE_PIN;
    end else if (ihit) begin
      vec_next = mip_pkg::ivec(widx); // [R3] [R4] [R18]
      cls_next = mip_pkg::CLS_IBIT;
    end else begin
      any_next = 1'b0;
    end
  end

  // Requests are only sampled at an instruction boundary
  always_ff @(posedge clock) begin
    if (!nrst) begin
      state_reg <= mip_pkg::ST_IDLE;
      irq_valid <= 1'b0;
      irq_vector <= 16'h0000;
      cls_reg <= mip_pkg::CLS_RESET;
      sel_idx_reg <= 4'h0;
    end else begin
      case (state_reg)
        mip_pkg::ST_IDLE: begin
          if (swi_begin) begin // [R9]
            state_reg <= mip_pkg::ST_SWI;
            irq_valid <= 1'b1;
            irq_vector <= mip_pkg::VEC_SWI; // [R5]
            cls_reg <= mip_pkg::CLS_SWI;
          end else if (insn_boundary && any_next) begin // [R2]
            state_reg <= mip_pkg::ST_PRESENT;
            irq_valid <= 1'b1;
            irq_vector <= vec_next; // [R24]
            cls_reg <= cls_next;
            sel_idx_reg <= widx;
          end
        end
        mip_pkg::ST_PRESENT, mip_pkg::ST_SWI: begin
          // Vector stays frozen until the sequencer takes it
          if (vector_taken) begin
            state_reg <= mip_pkg::ST_IDLE;
            irq_valid <= 1'b0;
          end
        end
        default: begin
          state_reg <= mip_pkg::ST_IDLE;
          irq_valid <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) swi_fetch_ok <= 1'b0;
    else swi_fetch_ok <= !any_next && state_reg == mip_pkg::ST_IDLE; // [R9]
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mask bits; hardware setting on service outranks the instructions
  always_ff @(posedge clock) begin
    if (!nrst) begin
      x_mask <= 1'b1; // [R11]
    end else if (take && cls_reg == mip_pkg::CLS_PSEUDO_NONMASKABLE_PIN) begin
      x_mask <= 1'b1; // [R14]
    end else if (rti_exec) begin
      x_mask <= rti_x; // [R15]
    end else if (tap_write) begin
      x_mask <= x_mask && tap_x; // [R12]
    end
  end
  always_ff @(posedge clock) begin
    if (!nrst) begin
      i_mask <= 1'b1; // [R11]
    end else if (take && cls_reg != mip_pkg::CLS_RESET) begin
      i_mask <= 1'b1; // [R13] [R14] [R9]
    end else if (rti_exec) begin
      i_mask <= rti_i; // [R15]
    end else if (tap_write) begin
      i_mask <= tap_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    case (reg_addr)
      mip_pkg::ADDR_CFG: rd_mux = cfg_reg;
      mip_pkg::ADDR_PROMO: rd_mux = {4'h0, promo_reg};
      mip_pkg::ADDR_EN_PER: rd_mux = en_per_reg;
      mip_pkg::ADDR_EN_TMR: rd_mux = en_tmr_reg;
      mip_pkg::ADDR_EN_SER: rd_mux = {4'h0, en_ser_reg};
      // Valid, X, I, window open, edge latched
      mip_pkg::ADDR_STATUS: rd_mux = {irq_valid, x_mask, i_mask,
                                      window_open, edge_flag_reg, 3'h0};
      mip_pkg::ADDR_VEC_LO: rd_mux = irq_vector[7:0];
      default: rd_mux = 8'h00;
    endcase
  end
  always_ff @(posedge clock) begin
    if (!nrst) reg_rdata <= 8'h00;
    else if (reg_rd) reg_rdata <= rd_mux;
    else reg_rdata <= 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  property p_edge_latch;
    edge_mode && ext_fall |=> edge_flag_reg;
  endproperty
  a_edge_latch: assert property (p_edge_latch) // [R1]
    else $error("falling edge not latched");
  property p_boundary;
    $rose(irq_valid) |-> $past(insn_boundary) || $past(swi_begin);
  endproperty
  a_boundary: assert property (p_boundary) // [R2]
    else $error("request presented off an instruction boundary");
  property p_ivec_range;
    irq_valid && cls_reg == mip_pkg::CLS_IBIT |->
      irq_vector >= mip_pkg::VEC_SCI && irq_vector <= mip_pkg::VEC_IRQ &&
      !irq_vector[0];
  endproperty
  a_ivec_range: assert property (p_ivec_range) // [R3]
    else $error("I source vector out of range");
  property p_reset_first;
    state_reg == mip_pkg::ST_IDLE && !swi_begin && insn_boundary &&
      rst_pend_reg |=> irq_vector == mip_pkg::VEC_RESET;
  endproperty
  a_reset_first: assert property (p_reset_first) // [R17]
    else $error("reset vector not presented first");
  property p_swi_hold;
    state_reg == mip_pkg::ST_SWI && !vector_taken |=>
      irq_valid && irq_vector == mip_pkg::VEC_SWI;
  endproperty
  a_swi_hold: assert property (p_swi_hold) // [R9]
    else $error("software trap preempted");
  property p_reset_masks;
    $past(!nrst) |-> x_mask && i_mask;
  endproperty
  a_reset_masks: assert property (p_reset_masks) // [R11]
    else $error("masks not set by reset");
  property p_x_sticky;
    !x_mask && !(take && cls_reg == mip_pkg::CLS_PSEUDO_NONMASKABLE_PIN) && !rti_exec
      |=> !x_mask;
  endproperty
  a_x_sticky: assert property (p_x_sticky) // [R12]
    else $error("software set X");
  property p_ibit_service;
    take && cls_reg == mip_pkg::CLS_IBIT |=>
      i_mask && x_mask == $past(x_mask);
  endproperty
  a_ibit_service: assert property (p_ibit_service) // [R13]
    else $error("I service masks wrong");
  property p_pseudo_nonmaskable_pin_service;
    take && cls_reg == mip_pkg::CLS_PSEUDO_NONMASKABLE_PIN |=> x_mask && i_mask;
  endproperty
  a_pseudo_nonmaskable_pin_service: assert property (p_pseudo_nonmaskable_pin_service) // [R14]
    else $error("pin NMI service masks wrong");
  property p_promo_lock;
    !i_mask |=> promo_reg == $past(promo_reg);
  endproperty
  a_promo_lock: assert property (p_promo_lock) // [R19]
    else $error("promote written with I clear");
  property p_cme_gate;
    !clock_monitor_enable |=> !clock_monitor_reset;
  endproperty
  a_cme_gate: assert property (p_cme_gate) // [R20]
    else $error("clock reset while monitor disabled");
  property p_prot_lock;
    !prot_ok |=> (cfg_reg & mip_pkg::CFG_PROT_MASK) ==
                 ($past(cfg_reg) & mip_pkg::CFG_PROT_MASK);
  endproperty
  a_prot_lock: assert property (p_prot_lock) // [R21]
    else $error("protected option bits changed");

  c_ibit: cover property (take && cls_reg == mip_pkg::CLS_IBIT);
  c_pseudo_nonmaskable_pin: cover property (take && cls_reg == mip_pkg::CLS_PSEUDO_NONMASKABLE_PIN);
  c_swi: cover property (take && cls_reg == mip_pkg::CLS_SWI);
  c_promo: cover property (ihit && widx != 4'h0 &&
                           widx == mip_pkg::promo_to_idx(promo_reg));
endmodule

/* sim/mip_cpu_model.sv */
module mip_cpu_model (
  input wire logic clock,
  input wire logic nrst,
  input wire logic slow,
  input wire logic irq_valid,
  output logic vector_taken
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] wait_reg;
  // Slow stacking keeps the vector standing for several cycles
  always_ff @(posedge clock) begin
    if (!nrst || !irq_valid || vector_taken) begin
      wait_reg <= 3'h0;
      vector_taken <= 1'b0;
    end else if (wait_reg == (slow ? 3'h5 : 3'h0)) begin
      vector_taken <= 1'b1;
    end else begin
      wait_reg <= wait_reg + 3'h1;
    end
  end
endmodule

/* sim/testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, nrst, wr, rd, wd, il, tx, ti, rx, ri, vt, ep, ok;
  logic [3:0] st;
  logic slow, cs, xp, v, x, i, cmr;
  logic [2:0] a;
  logic [7:0] wdat, rdat;
  logic [14:0] rq;
  logic [4:0] sx;
  logic [15:0] vec;
  logic [3:0] pc;
  int error_cnt, compares, cyc, k;
  mip_top u_dut (.clock(clock), .nrst(nrst), .reg_addr(a),
    .reg_wdata(wdat), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat),
    .special_test_mode(1'b0), .ext_request_n_pin(ep),
    .pseudo_nonmaskable_pin_n(xp), .clock_slow_detect(cs),
    .watchdog_fail(wd), .illegal_opcode(il), .insn_boundary(st[0]),
    .swi_begin(st[3]), .tap_write(st[1]), .tap_x(tx), .tap_i(ti),
    .rti_exec(st[2]), .rti_x(rx), .rti_i(ri), .vector_taken(vt),
    .serial_periph_req(rq[13]), .accum_edge_req(rq[12]),
    .accum_overflow_req(rq[11]), .timer_wrap_req(rq[10]),
    .compare_req(rq[9:5]), .capture_req(rq[4:2]),
    .periodic_tick_req(rq[1]), .strobe_handshake_req(rq[0]),
    .rx_full_req(sx[0]), .rx_overrun_req(sx[1]),
    .line_idle_req(sx[2]), .tx_empty_req(sx[3]), .tx_done_req(sx[4]),
    .irq_valid(v), .irq_vector(vec), .x_mask(x), .i_mask(i),
    .swi_fetch_ok(ok), .clock_monitor_reset(cmr));
  mip_cpu_model u_cpu (.clock(clock), .nrst(nrst), .slow(slow),
    .irq_valid(v), .vector_taken(vt));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc > 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, exp, input string m);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic pulse(input int n);
    @(posedge clock) st[n] <= 1'b1;
    @(posedge clock) st[n] <= 1'b0;
  endtask
  task automatic wreg(input logic [2:0] ad, input logic [7:0] d);
    @(posedge clock) begin a <= ad; wdat <= d; wr <= 1'b1; end
    @(posedge clock) wr <= 1'b0;
  endtask
  task automatic rreg(input logic [2:0] ad, input logic [7:0] e);
    @(posedge clock) begin a <= ad; rd <= 1'b1; end
    @(posedge clock) rd <= 1'b0;
    #1 chk(16'(rdat), 16'(e), "read");
  endtask
  task automatic tap(input logic nx, ni);
    @(posedge clock) begin tx <= nx; ti <= ni; end
    pulse(1);
    @(posedge clock);
  endtask
  task automatic bnd(input logic [15:0] e);
    int n;
    n = 0;
    @(posedge clock) slow <= 1'($urandom_range(1, 0));
    pulse(0);
    #1;
    while (v !== 1'b1 && n < 8) begin @(posedge clock); #1; n++; end
    chk(vec, e, "vector");
    while (v !== 1'b0 && n < 30) begin @(posedge clock); #1; n++; end
    chk(16'(v), 16'h0, "release");
  endtask
  task automatic setrq(input logic [14:0] q);
    @(posedge clock) begin
      rq <= q;
      sx <= q[14] ? 5'($urandom_range(31, 1)) : 5'h00;
    end
  endtask
  function automatic int pidx(input logic [3:0] c);
    if (c <= 4'h4) return 10 + c;
    if (c <= 4'h6) return 0;
    return c - 6;
  endfunction
  function automatic int win(input logic [14:0] q, input logic [3:0] c);
    if (q[pidx(c)]) return pidx(c);
    for (int j = 0; j < 15; j++) if (q[j]) return j;
    return 0;
  endfunction
  task automatic report_and_stop();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    {nrst, wr, rd, wd, il, tx, ti, rx, ri, slow, st} = '0;
    {a, wdat, rq, sx} = '0;
    {cs, xp, ep} = 3'b111;
    void'($urandom(32'h8b3c));
    repeat (6) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock) #1 chk(16'({x, i}), 16'h3, "masks");
    rreg(3'h1, 8'h05);
    rreg(3'h0, 8'h10);
    bnd(16'hFFFE);
    wreg(3'h0, 8'h30);
    wreg(3'h2, 8'h3F);
    wreg(3'h3, 8'hFF);
    wreg(3'h4, 8'h0F);
    tap(1'b0, 1'b0);
    chk(16'({x, i}), 16'h0, "tap clear");
    wreg(3'h1, 8'h00);
    rreg(3'h1, 8'h05);
    for (k = 0; k < 15; k++) begin
      setrq(15'(1) << k);
      tap(1'b1, 1'b0);
      bnd(16'hFFF2 - 16'(2 * k));
      chk(16'({x, i}), 16'h1, "i set");
    end
    @(posedge clock) ep <= 1'b0;
    repeat (3) @(posedge clock);
    rreg(3'h5, 8'h28);
    tap(1'b1, 1'b0);
    bnd(16'hFFF2);
    rreg(3'h5, 8'h20);
    for (k = 0; k < 40; k++) begin
      pc = 4'($urandom_range(15, 0));
      setrq(15'($urandom_range(32767, 1)));
      wreg(3'h1, {4'h0, pc});
      tap(1'b1, 1'b0);
      bnd(16'hFFF2 - 16'(2 * win(rq, pc)));
    end
    tap(1'b0, 1'b0);
    @(posedge clock) xp <= 1'b0;
    repeat (5) @(posedge clock);
    bnd(16'hFFF4);
    chk(16'({x, i}), 16'h3, "x and i");
    @(posedge clock) begin xp <= 1'b1; rx <= 1'b0; ri <= 1'b1; end
    pulse(2);
    @(posedge clock) #1 chk(16'({x, i}), 16'h1, "restore");
    tap(1'b1, 1'b0);
    chk(16'(x), 16'h0, "x stays clear");
    setrq('0);
    @(posedge clock) #1 chk(16'(ok), 16'h1, "trap allowed");
    pulse(3);
    #1 chk(vec, 16'hFFF6, "trap vector");
    wait (v === 1'b0);
    #1 chk(16'({x, i}), 16'h1, "trap masks");
    @(posedge clock) begin wd <= 1'b1; il <= 1'b1; end
    @(posedge clock) begin wd <= 1'b0; il <= 1'b0; end
    @(posedge clock) #1 chk(16'(ok), 16'h0, "trap blocked");
    bnd(16'hFFFA);
    bnd(16'hFFF8);
    wreg(3'h0, 8'h18);
    rreg(3'h0, 8'h38);
    @(posedge clock) cs <= 1'b0;
    repeat (5) @(posedge clock);
    chk(16'(cmr), 16'h1, "clock fail");
    bnd(16'hFFFC);
    report_and_stop();
  end
endmodule
